// ### src/floppy_read_data_command.sv
// How it works
// - after the last command byte, sector data flows drive to system
// - result phase returns three status bytes then four sector identity bytes
// - returned identity is the one reached after execution
// - with omit_deleted_flag set, read data passes over deleted sectors
// - with the flag set, read deleted data touches only deleted sectors
// - with the flag clear, every sector is read regardless of mark
// - step pulses spaced by step_rate_interval, 0.5 to 8 ms
// - relative seek adds relative_cylinder to present cylinder
// - sectors_per_track_count bounds format and counted verify
// - four status registers hold status after each command
// - write_gate_timing shifts write enable earlier for pre-erase
// - multi_track continues from last sector of head 0 onto head 1
// - density_select one gives double density, zero single
// - sector length 128 times two to the size code, codes above 7 held at 7; code 0 uses data_length
`timescale 1ns/10ps
`default_nettype none
`include "floppy_defs.svh"
module floppy_read_data_command
   import floppy_pkg::*;
#(
   parameter int STEP_UNIT = `STEP_UNIT_CYC
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // host byte port
   input wire logic cmd_wr,
   input wire logic [7:0] cmd_data,
   input wire logic res_rd,
   output logic [7:0] res_data,
   output logic res_valid,
   output logic cmd_ready,
   // configuration
   input wire logic [3:0] step_rate_interval,
   input wire logic seek_relative,
   input wire logic [7:0] relative_cylinder,
   input wire logic [7:0] sectors_per_track_count,
   input wire logic verify_count_enable,
   input wire logic write_gate_timing,
   input wire logic write_req,
   // drive side sector stream (pins)
   input wire logic sec_valid_pin,
   input wire logic sec_deleted_pin,
   input wire logic [7:0] sec_byte_pin,
   // system side data
   output logic [7:0] xfer_data,
   output logic xfer_valid,
   // drive control
   output logic step_pulse,
   output logic head_sel,
   output logic [1:0] drive_sel,
   output logic double_density,
   output logic write_enable,
   output logic busy,
   output logic [7:0] status_three
);
   // =====================================
   // pin synchronisers
   logic [9:0] pin_s1_ff;
   logic [9:0] pin_s2_ff;
   logic sec_valid_d_ff;
   always_ff @(posedge clk) begin
      if (rst) begin
         pin_s1_ff <= 10'h0;
         pin_s2_ff <= 10'h0;
         sec_valid_d_ff <= 1'b0;
      end else if (ce) begin
         pin_s1_ff <= {sec_valid_pin, sec_deleted_pin, sec_byte_pin};
         pin_s2_ff <= pin_s1_ff;
         sec_valid_d_ff <= pin_s2_ff[9];
      end
   end
   wire s_valid = pin_s2_ff[9];
   wire s_deleted = pin_s2_ff[8];
   wire [7:0] s_byte = pin_s2_ff[7:0];
   wire sec_begin = s_valid & ~sec_valid_d_ff;
   wire sec_end = ~s_valid & sec_valid_d_ff;

   // =====================================
   // state
   phase_t phase_ff, nxt_phase;
   logic [3:0] idx_ff;
   logic [7:0] cmd_ff [0:8];
   logic [7:0] status_ff [0:3];
   logic [7:0] cyl_pos_ff;
   logic [7:0] target_ff;
   logic [15:0] byte_cnt_ff;
   logic accept_ff;
   logic del_seen_ff;
   logic [7:0] sec_done_ff;
   logic [7:0] wg_cnt_ff;

   wire op_is_read = (cmd_ff[0][4:0] == `OPC_READ_LOW);
   wire op_is_rdel = (cmd_ff[0][4:0] == `OPC_READ_DEL_LOW);
   wire multi_track = cmd_ff[0][`OPC_MT_BIT];
   wire skip = cmd_ff[0][`OPC_SKIP_BIT];
   wire [7:0] cyl = cmd_ff[2];
   wire [7:0] hd = cmd_ff[3];
   wire [7:0] sec = cmd_ff[4];
   wire [7:0] end_of_track = cmd_ff[6];

   function automatic logic [15:0] sec_len(input logic [7:0] code, input logic [7:0] data_length);
      if (code == 8'h00) sec_len = {8'h00, data_length};
      else if (code > `SIZE_CODE_MAX) sec_len = `SECTOR_BASE_BYTES << `SIZE_CODE_MAX;
      else sec_len = `SECTOR_BASE_BYTES << code[2:0];
   endfunction : sec_len

   // choose whether a sector is transferred
   wire take_sector = !skip ? 1'b1 : (op_is_rdel ? s_deleted : !s_deleted);
   // the first byte comes with the sector start, so judge it on fresh values
   wire cur_accept = sec_begin ? take_sector : accept_ff;
   wire [15:0] cur_cnt = sec_begin ? sec_len(cmd_ff[5], cmd_ff[8]) : byte_cnt_ff;
   wire byte_take = (phase_ff == PH_EXEC) && s_valid && cur_accept && (cur_cnt != 16'h0);
   // verify and format stop on the sector count when enabled
   wire count_stop = verify_count_enable && (sec_done_ff + 8'h1 >= sectors_per_track_count);
   // a passed-over sector still moves the identity on, only taken ones count
   wire at_track_end = (sec == end_of_track);
   wire last_sector = at_track_end && (!multi_track || hd[0]) || (count_stop && accept_ff);
   // target is latched at command end; a live sum would chase the moving head
   wire [7:0] seek_target = seek_relative ? cyl_pos_ff + relative_cylinder : cyl;
   wire [7:0] step_next = (cyl_pos_ff < target_ff) ? cyl_pos_ff + 8'h1 : cyl_pos_ff - 8'h1;
   wire step_ready;
   wire need_step = (cyl_pos_ff != target_ff);
   wire do_step = (phase_ff == PH_SEEK) && need_step && step_ready;
   wire last_res = (idx_ff == `RES_BYTES - 4'h1);

   step_timer #(.UNIT_CYC(STEP_UNIT)) u_step (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .start(do_step),
      .rate(step_rate_interval),
      .ready(step_ready)
   );

   always_comb begin
      nxt_phase = phase_ff;
      case (phase_ff)
         PH_CMD: if (cmd_wr && idx_ff == `CMD_BYTES - 4'h1) nxt_phase = PH_SEEK;
         PH_SEEK: if (!need_step && step_ready) nxt_phase = PH_EXEC;
         PH_EXEC: if (sec_end && last_sector) nxt_phase = PH_RES;
         PH_RES: if (res_rd && last_res) nxt_phase = PH_CMD;
         default: nxt_phase = PH_CMD;
      endcase
   end

   // =====================================
   // result byte selection
   wire [3:0] res_idx = (phase_ff == PH_RES && res_rd) ? idx_ff + 4'h1 : idx_ff;
   wire [7:0] res_sel = (res_idx < 4'h3) ? status_ff[res_idx[1:0]] : cmd_ff[res_idx - 4'h1];

   always_ff @(posedge clk) begin
      if (rst) begin
         phase_ff <= PH_CMD;
         idx_ff <= 4'h0;
         cyl_pos_ff <= 8'h00;
         target_ff <= 8'h00;
         byte_cnt_ff <= 16'h0;
         accept_ff <= 1'b0;
         del_seen_ff <= 1'b0;
         sec_done_ff <= 8'h00;
         for (int i = 0; i < 9; i++) cmd_ff[i] <= 8'h00;
         for (int i = 0; i < 4; i++) status_ff[i] <= 8'h00;
      end else if (ce) begin
         phase_ff <= nxt_phase;
         if (phase_ff == PH_CMD && cmd_wr) begin
            cmd_ff[idx_ff] <= cmd_data;
            idx_ff <= (idx_ff == `CMD_BYTES - 4'h1) ? 4'h0 : idx_ff + 4'h1;
         end
         if (phase_ff == PH_CMD && nxt_phase == PH_SEEK) begin
            sec_done_ff <= 8'h00;
            del_seen_ff <= 1'b0;
            target_ff <= seek_target;
         end
         if (do_step) cyl_pos_ff <= step_next;
         if (phase_ff == PH_EXEC && s_valid) begin
            accept_ff <= cur_accept;
            byte_cnt_ff <= byte_take ? cur_cnt - 16'h1 : cur_cnt;
         end
         if (phase_ff == PH_EXEC && sec_begin && take_sector && s_deleted) del_seen_ff <= 1'b1;
         if (phase_ff == PH_EXEC && sec_end) begin
            if (accept_ff) sec_done_ff <= sec_done_ff + 8'h1;
            // advance the stored identity as sectors complete
            if (at_track_end && multi_track && !hd[0]) begin
               cmd_ff[1][`SEL_HEAD_BIT] <= 1'b1;
               cmd_ff[3] <= hd ^ 8'h01;
               cmd_ff[4] <= 8'h01;
            end else if (at_track_end) begin
               cmd_ff[2] <= cyl + 8'h1;
               cmd_ff[4] <= 8'h01;
            end else cmd_ff[4] <= sec + 8'h1;
         end
         if (phase_ff == PH_EXEC && nxt_phase == PH_RES) begin
            status_ff[0] <= {6'h00, cmd_ff[1][1:0]} | (op_is_read | op_is_rdel ? 8'h00 : 8'h80);
            status_ff[1] <= {7'h00, accept_ff && byte_cnt_ff != 16'h0};
            status_ff[2] <= {1'b0, del_seen_ff, 6'h00};
            status_ff[3] <= {3'h0, cyl_pos_ff == 8'h00, 1'b0, cmd_ff[1][2:0]};
         end
         if (phase_ff == PH_RES && res_rd) idx_ff <= last_res ? 4'h0 : idx_ff + 4'h1;
      end
   end

   // =====================================
   // registered outputs
   always_ff @(posedge clk) begin
      if (rst) begin
         res_data <= 8'h00;
         res_valid <= 1'b0;
         cmd_ready <= 1'b1;
         xfer_data <= 8'h00;
         xfer_valid <= 1'b0;
         step_pulse <= 1'b0;
         head_sel <= 1'b0;
         drive_sel <= 2'b00;
         double_density <= 1'b0;
         write_enable <= 1'b0;
         busy <= 1'b0;
         status_three <= 8'h00;
         wg_cnt_ff <= 8'h00;
      end else if (ce) begin
         // one cycle after entry, so the status captured on entry is what shows
         res_data <= (phase_ff == PH_RES && nxt_phase == PH_RES) ? res_sel : 8'h00;
         res_valid <= (phase_ff == PH_RES) && (nxt_phase == PH_RES);
         cmd_ready <= (nxt_phase == PH_CMD);
         // only accepted sector bytes go to the system
         xfer_valid <= byte_take;
         xfer_data <= s_byte;
         step_pulse <= do_step;
         head_sel <= cmd_ff[1][`SEL_HEAD_BIT];
         drive_sel <= cmd_ff[1][1:0];
         double_density <= cmd_ff[0][`OPC_DENS_BIT];
         // pre-erase mode raises write enable a fixed lead before data
         if (!write_req) wg_cnt_ff <= 8'h00;
         else if (wg_cnt_ff != `WRITE_LEAD_CYC) wg_cnt_ff <= wg_cnt_ff + 8'h1;
         write_enable <= write_req && (write_gate_timing || wg_cnt_ff == `WRITE_LEAD_CYC);
         busy <= (nxt_phase != PH_CMD);
         status_three <= status_ff[3];
      end
   end
endmodule : floppy_read_data_command
`default_nettype wire

// ### inc/floppy_defs.svh
`ifndef FLOPPY_DEFS_SVH
`define FLOPPY_DEFS_SVH
// opcode layout
`define OPC_MT_BIT 7
`define OPC_DENS_BIT 6
`define OPC_SKIP_BIT 5
`define OPC_READ_LOW 5'h06
`define OPC_READ_DEL_LOW 5'h0c
// second byte layout
`define SEL_HEAD_BIT 2
// phase counts
`define CMD_BYTES 4'h9
`define RES_BYTES 4'h7
// size codes
`define SIZE_CODE_MAX 8'h07
`define SECTOR_BASE_BYTES 16'h0080
// step timing
`define STEP_UNIT_US 500
`define CLK_MHZ 250
`define STEP_UNIT_CYC (`STEP_UNIT_US * `CLK_MHZ)
// write gate pre-erase lead
`define WRITE_LEAD_CYC 8'h10
`endif

// ### inc/floppy_pkg.sv
package floppy_pkg;
   typedef enum logic [2:0] {
      PH_CMD = 3'b000,
      PH_SEEK = 3'b001,
      PH_EXEC = 3'b010,
      PH_RES = 3'b011,
      PH_NEXT = 3'b100
   } phase_t;
endpackage : floppy_pkg

// ### src/step_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "floppy_defs.svh"
// =====================================
// step pulse pacing
module step_timer #(
   parameter int UNIT_CYC = `STEP_UNIT_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // control
   input wire logic start,
   input wire logic [3:0] rate,
   output logic ready
);
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   // interval is (rate+1) half-millisecond units, 0.5 to 8 ms
   wire [31:0] span = 32'(UNIT_CYC) * (32'(rate) + 32'h1);
   assign nxt_cnt = start ? span : ((cnt_ff != 32'h0) ? cnt_ff - 32'h1 : cnt_ff);
   assign ready = (cnt_ff == 32'h0);
   always_ff @(posedge clk) begin
      if (rst) cnt_ff <= 32'h0;
      else if (ce) cnt_ff <= nxt_cnt;
   end
endmodule : step_timer
`default_nettype wire

// ### testbench/floppy_properties.sv
`timescale 1ns/10ps
`default_nettype none
// =====
// port checker
module floppy_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // host side
   input wire logic res_rd,
   input wire logic [7:0] res_data,
   input wire logic res_valid,
   input wire logic cmd_ready,
   input wire logic busy,
   input wire logic xfer_valid,
   // drive side
   input wire logic step_pulse,
   input wire logic write_gate_timing,
   input wire logic write_req,
   input wire logic write_enable
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_hold; res_valid && !res_rd; endsequence
   sequence s_slow; !write_gate_timing && write_req; endsequence
   property p_phase; cmd_ready |-> !busy && !res_valid; endproperty
   a_phase: assert property (p_phase) else $error("phases overlap");
   property p_xfer; xfer_valid |-> busy && !res_valid; endproperty
   a_xfer: assert property (p_xfer) else $error("data outside execution");
   property p_hold; s_hold |=> res_valid && $stable(res_data); endproperty
   a_hold: assert property (p_hold) else $error("result byte moved");
   property p_back; $fell(res_valid) |-> ##[0:1] cmd_ready; endproperty
   a_back: assert property (p_back) else $error("no return to commands");
   property p_step; step_pulse |=> !step_pulse [*3]; endproperty
   a_step: assert property (p_step) else $error("steps too close");
   property p_fast; write_gate_timing && write_req |=> write_enable; endproperty
   a_fast: assert property (p_fast) else $error("write enable late");
   property p_lead; s_slow [*1] ##0 !$past(write_req) |=> !write_enable [*8]; endproperty
   a_lead: assert property (p_lead) else $error("write enable early");
   // a long hold is split since repetition counts stay small
   property p_late; s_slow [*8] ##1 s_slow [*8] ##1 s_slow [*4] |=> write_enable; endproperty
   a_late: assert property (p_late) else $error("write enable missing");
endmodule : floppy_checker
bind floppy_read_data_command floppy_checker u_chk (.*);
`default_nettype wire

// ### testbench/drive_model.sv
`timescale 1ns/10ps
`default_nettype none
// =====
// drive sector stream
module drive_model #(
   parameter int LEN = 4
) (
   // control
   input wire logic clk,
   input wire logic go,
   input wire logic del,
   input wire logic [7:0] base,
   // pins
   output logic sec_valid_pin,
   output logic sec_deleted_pin,
   output logic [7:0] sec_byte_pin
);
   int cnt_ff = 0;
   logic del_ff = 1'b0;
   logic [7:0] byte_ff = 8'h00;
   assign sec_valid_pin = cnt_ff != 0;
   assign sec_deleted_pin = sec_valid_pin & del_ff;
   // idle data keeps counting so a stale byte never looks valid
   assign sec_byte_pin = byte_ff;
   always_ff @(posedge clk) begin
      del_ff <= go ? del : del_ff;
      byte_ff <= go ? base : byte_ff + 8'h01;
      cnt_ff <= go ? LEN : (cnt_ff == 0 ? 0 : cnt_ff - 1);
   end
endmodule : drive_model
`default_nettype wire

// ### testbench/floppy_read_data_command_bench.sv
`timescale 1ns/10ps
`default_nettype none
// =====
// read data bench
module floppy_read_data_command_bench;
   logic clk = 1'b0, rst = 1'b1, cmd_wr = 1'b0, res_rd = 1'b0, go = 1'b0, del = 1'b0;
   logic seek_relative = 1'b0, write_gate_timing = 1'b0, write_req = 1'b0;
   logic verify_count_enable = 1'b0;
   logic [7:0] sectors_per_track_count = 8'h00;
   logic [7:0] cmd_data = 8'h00, relative_cylinder = 8'h00, base = 8'h00;
   logic [3:0] step_rate_interval = 4'h1;
   logic [7:0] res_data, xfer_data, status_three, sec_byte_pin;
   logic [1:0] drive_sel;
   logic res_valid, cmd_ready, xfer_valid, step_pulse, head_sel, double_density;
   logic write_enable, busy, sec_valid_pin, sec_deleted_pin;
   logic [7:0] res [7];
   logic [7:0] got [$];
   int err_count = 0;
   int total_checks = 0;
   int steps = 0;
   floppy_read_data_command #(.STEP_UNIT(4)) uut (.ce(1'b1), .*);
   drive_model dm (.*);
   initial forever #2 clk = ~clk;
   always @(negedge clk) begin
      if (step_pulse === 1'b1) steps++;
      if (xfer_valid === 1'b1) got.push_back(xfer_data);
   end
   task chk(input logic [7:0] g, input logic [7:0] e);
      total_checks++;
      if (g !== e) begin
         $display("FAIL t=%0t got %h exp %h", $time, g, e);
         err_count++;
      end
   endtask : chk
   task test_done;
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : test_done
   task cmd9(input logic [71:0] c);
      for (int i = 0; i < 9; i++) begin
         @(posedge clk);
         cmd_wr <= 1'b1;
         cmd_data <= c[71-8*i -: 8];
      end
      @(posedge clk);
      cmd_wr <= 1'b0;
      @(negedge clk);
   endtask : cmd9
   task seek(input int n);
      int k;
      for (k = 0; k < 400 && steps < n; k++) @(negedge clk);
      if (k == 400) begin
         err_count++;
         test_done;
      end
      // an extra step would land inside this spacing window
      repeat (20) @(negedge clk);
      chk(8'(steps), 8'(n));
   endtask : seek
   task sector(input logic d, input logic [7:0] b);
      @(posedge clk);
      go <= 1'b1;
      del <= d;
      base <= b;
      @(posedge clk);
      go <= 1'b0;
      repeat (16) @(posedge clk);
   endtask : sector
   task results;
      int k;
      for (int i = 0; i < 7; i++) begin
         // sample away from the edge that moves res_data
         @(negedge clk);
         for (k = 0; k < 500 && res_valid !== 1'b1; k++) @(negedge clk);
         if (k == 500) begin
            err_count++;
            test_done;
         end
         res[i] = res_data;
         @(posedge clk);
         res_rd <= 1'b1;
         @(posedge clk);
         res_rd <= 1'b0;
      end
      repeat (2) @(negedge clk);
      chk(8'(cmd_ready), 8'h01);
   endtask : results
   task t_plain;
      cmd9({8'h46, 8'h05, 8'h02, 8'h00, 8'h01, 8'h00, 8'h02, 8'h1b, 8'h04});
      chk(8'(double_density), 8'h01);
      chk(8'({head_sel, drive_sel}), 8'h05);
      seek(2);
      sector(1'b0, 8'h10);
      sector(1'b1, 8'h20);
      results;
      chk(8'(got.size()), 8'h08);
      chk(got[4], 8'h20);
      chk(res[0] & 8'h03, 8'h01);
      chk(res[2] & 8'h40, 8'h40);
      chk(res[6], 8'h00);
      chk(res[3], 8'h03);
      chk(res[1], 8'h00);
      chk(status_three, 8'h05);
      $display("t_plain done");
   endtask : t_plain
   task t_skip;
      steps = 0;
      got.delete();
      seek_relative <= 1'b1;
      relative_cylinder <= 8'h03;
      verify_count_enable <= 1'b1;
      sectors_per_track_count <= 8'h01;
      cmd9({8'h26, 8'h00, 8'h09, 8'h00, 8'h01, 8'h00, 8'h05, 8'h1b, 8'h04});
      chk(8'(double_density), 8'h00);
      seek(3);
      sector(1'b1, 8'h30);
      sector(1'b0, 8'h40);
      results;
      chk(8'(got.size()), 8'h04);
      chk(got[0], 8'h40);
      chk(res[5], 8'h03);
      $display("t_skip done");
   endtask : t_skip
   task t_rdel;
      steps = 0;
      got.delete();
      verify_count_enable <= 1'b0;
      relative_cylinder <= 8'hfe;
      cmd9({8'hac, 8'h00, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01, 8'h1b, 8'h04});
      seek(2);
      sector(1'b0, 8'h50);
      sector(1'b1, 8'h60);
      results;
      chk(8'(got.size()), 8'h04);
      chk(got[0], 8'h60);
      chk(res[2] & 8'h40, 8'h40);
      chk(res[4], 8'h01);
      chk(8'(head_sel), 8'h01);
      $display("t_rdel done");
   endtask : t_rdel
   task t_write_gate_timing;
      int n;
      for (int t = 0; t < 2; t++) begin
         @(posedge clk);
         write_gate_timing <= t[0];
         @(posedge clk);
         write_req <= 1'b1;
         for (n = 0; n < 40 && write_enable !== 1'b1; n++) @(negedge clk);
         if (n == 40) begin
            err_count++;
            test_done;
         end
         chk(8'(n >= 16), 8'(t == 0));
         repeat (5) @(posedge clk);
         write_req <= 1'b0;
         repeat (4) @(posedge clk);
      end
      $display("t_write_gate_timing done");
   endtask : t_write_gate_timing
   initial begin
      repeat (8) @(posedge clk);
      rst <= 1'b0;
      t_plain;
      t_skip;
      t_rdel;
      t_write_gate_timing;
      test_done;
   end
endmodule : floppy_read_data_command_bench
`default_nettype wire
